// *** rtl/ddspr_pkg.sv ***
package ddspr_pkg;
  // Register addresses on the serial configuration port.
  localparam logic [7:0] DDSPR_ADDR_STEP = 8'h0c;
  localparam logic [7:0] DDSPR_ADDR_RATE = 8'h0d;
  localparam logic [7:0] DDSPR_ADDR_PROF_FIRST = 8'h0e;
  localparam logic [7:0] DDSPR_ADDR_PROF_LAST = 8'h15;
  // Control word bit positions.
  localparam int DDSPR_CW1_MEM_EN = 31;
  localparam int DDSPR_CW1_SEQ_LO = 17;
  localparam int DDSPR_CW2_RAMP_EN = 19;
  localparam int DDSPR_CW2_BIT4 = 4;
  // Field masks of writable bits (other bits read back as zero), then reset values.
  localparam logic [63:0] DDSPR_TONE_MASK = 64'h3fff_ffff_ffff_ffff;
  localparam logic [63:0] DDSPR_MEM_MASK = 64'h00ff_ffff_c0ff_c02f;
  localparam logic [63:0] DDSPR_RESET_VAL = 64'h0;
  localparam logic [31:0] DDSPR_RATE_RESET = 32'h0;
endpackage

// *** rtl/ddspr_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module ddspr_regs
  import ddspr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register write and read port from the serial decoder.
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [63:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [63:0] rd_data,
  // Control words held elsewhere in the core.
  input wire logic [31:0] first_control_word,
  input wire logic [31:0] second_control_word,
  // Profile select pins and internal sequencer choice.
  input wire logic [2:0] profile_pins,
  input wire logic [2:0] seq_profile,
  // Ramp generator settings.
  output logic [31:0] ramp_dec_step,
  output logic [31:0] ramp_inc_step,
  output logic [15:0] ramp_neg_rate,
  output logic [15:0] ramp_pos_rate,
  // Active profile decode.
  output logic [2:0] active_profile,
  output logic mem_mode,
  output logic tone_mode,
  output logic [13:0] amplitude_scale,
  output logic [15:0] phase_offset_value,
  output logic [31:0] tuning_value,
  output logic [15:0] mem_step_rate,
  output logic [9:0] mem_end_addr,
  output logic [9:0] mem_start_addr,
  output logic mem_no_dwell,
  output logic mem_zero_cross,
  output logic [2:0] mem_play_mode
);

  logic [63:0] step_q;
  logic [31:0] rate_q;
  logic [63:0] prof_q [8];
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [63:0] cur;
  logic ramp_en, seq_auto;

  function automatic logic is_prof(input logic [7:0] a);
    return a >= DDSPR_ADDR_PROF_FIRST && a <= DDSPR_ADDR_PROF_LAST;
  endfunction

  // Profile bits kept depend on the current interpretation, so a
  // write stores only fields meaningful in that mode.
  function automatic logic [63:0] prof_mask(input logic mem);
    return mem ? DDSPR_MEM_MASK : DDSPR_TONE_MASK;
  endfunction

  assign ramp_en = second_control_word[DDSPR_CW2_RAMP_EN];
  assign mem_mode = first_control_word[DDSPR_CW1_MEM_EN];
  assign tone_mode = !first_control_word[DDSPR_CW1_MEM_EN] && !ramp_en
                     && !second_control_word[DDSPR_CW2_BIT4];
  assign seq_auto = mem_mode && (first_control_word[DDSPR_CW1_SEQ_LO +: 4] != 4'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= DDSPR_RESET_VAL;
    end else if (wr_en && wr_addr == DDSPR_ADDR_STEP) begin
      step_q <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= DDSPR_RATE_RESET;
    end else if (wr_en && wr_addr == DDSPR_ADDR_RATE) begin
      rate_q <= wr_data[31:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        prof_q[i] <= DDSPR_RESET_VAL;
      end
    end else if (wr_en && is_prof(wr_addr)) begin
      prof_q[3'(wr_addr - DDSPR_ADDR_PROF_FIRST)] <= wr_data & prof_mask(mem_mode);
    end
  end

  // Pins are asynchronous; a change is taken once stages two and three agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      pin_s1_q <= profile_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_q <= pin_s3_q;
      end
    end
  end

  assign active_profile = seq_auto ? seq_profile : pin_q;
  assign cur = prof_q[active_profile];

  // Ramp values are zeroed while the generator is off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_dec_step <= 32'h0;
      ramp_inc_step <= 32'h0;
      ramp_neg_rate <= 16'h0;
      ramp_pos_rate <= 16'h0;
    end else begin
      ramp_dec_step <= ramp_en ? step_q[63:32] : 32'h0;
      ramp_inc_step <= ramp_en ? step_q[31:0] : 32'h0;
      ramp_neg_rate <= ramp_en ? rate_q[31:16] : 16'h0;
      ramp_pos_rate <= ramp_en ? rate_q[15:0] : 16'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amplitude_scale <= 14'h0;
      phase_offset_value <= 16'h0;
      tuning_value <= 32'h0;
    end else if (tone_mode) begin
      amplitude_scale <= cur[61:48];
      phase_offset_value <= cur[47:32];
      tuning_value <= cur[31:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_step_rate <= 16'h0;
      mem_end_addr <= 10'h0;
      mem_start_addr <= 10'h0;
      mem_no_dwell <= 1'b0;
      mem_zero_cross <= 1'b0;
      mem_play_mode <= 3'h0;
    end else if (mem_mode) begin
      mem_step_rate <= cur[55:40];
      mem_end_addr <= cur[39:30];
      mem_start_addr <= cur[23:14];
      mem_no_dwell <= cur[5];
      mem_zero_cross <= cur[3];
      mem_play_mode <= cur[2:0];
    end
  end

  // Reserved bits are never stored, so reads return them as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 64'h0;
    end else if (rd_addr == DDSPR_ADDR_STEP) begin
      rd_data <= step_q;
    end else if (rd_addr == DDSPR_ADDR_RATE) begin
      rd_data <= {32'h0, rate_q};
    end else if (is_prof(rd_addr)) begin
      rd_data <= prof_q[3'(rd_addr - DDSPR_ADDR_PROF_FIRST)];
    end else begin
      rd_data <= 64'h0;
    end
  end

  chk_ramp_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(ramp_en) |-> ramp_inc_step == 32'h0 && ramp_neg_rate == 16'h0)
    else $error("ramp values leaked while generator off");
  chk_step_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && wr_addr == DDSPR_ADDR_STEP |=> step_q == $past(wr_data))
    else $error("step register not written");
  chk_rate_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && wr_addr == DDSPR_ADDR_RATE |=> rate_q == $past(wr_data[31:0]))
    else $error("rate register not written");
  chk_rate_fields: assert property (@(posedge clk) disable iff (!rst_n)
    $past(ramp_en) |-> ramp_neg_rate == $past(rate_q[31:16])
      && ramp_pos_rate == $past(rate_q[15:0]))
    else $error("rate fields misrouted");
  chk_tone_decode: assert property (@(posedge clk) disable iff (!rst_n)
    tone_mode |-> !mem_mode && !ramp_en)
    else $error("tone and memory modes overlap");
  chk_auto_select: assert property (@(posedge clk) disable iff (!rst_n)
    seq_auto |-> active_profile == seq_profile)
    else $error("sequencer choice ignored");
  chk_pin_select: assert property (@(posedge clk) disable iff (!rst_n)
    !seq_auto |-> active_profile == pin_q)
    else $error("pin choice ignored");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode && wr_en && is_prof(wr_addr) |=> (prof_q[$past(wr_addr[2:0]) - 3'h6] & ~DDSPR_MEM_MASK) == 64'h0)
    else $error("reserved bits stored");
  chk_tone_fields: assert property (@(posedge clk) disable iff (!rst_n)
    tone_mode |=> tuning_value == $past(cur[31:0]))
    else $error("tuning value misrouted");

  // The select pins settle in two steps: stages two and three must agree,
  // and the agreed value is taken on the following edge. A pin that is still
  // moving therefore costs at least four cycles before the profile follows it.
  sequence pins_agree;
    pin_s2_q == pin_s3_q;
  endsequence

  sequence pin_taken;
    ##1 pin_q == $past(pin_s3_q);
  endsequence

  sequence pins_differ;
    pin_s2_q != pin_s3_q;
  endsequence

  sequence pin_kept;
    ##1 $stable(pin_q);
  endsequence

  chk_pin_sync: assert property (@(posedge clk) disable iff (!rst_n)
    pins_agree |-> pin_taken)
    else $error("agreed pin value not taken");
  chk_pin_hold: assert property (@(posedge clk) disable iff (!rst_n)
    pins_differ |-> pin_kept)
    else $error("unsettled pin value taken");

  // Ramp outputs are registered copies, so each check looks one edge back.
  chk_step_fields: assert property (@(posedge clk) disable iff (!rst_n)
    $past(ramp_en) |-> ramp_dec_step == $past(step_q[63:32])
      && ramp_inc_step == $past(step_q[31:0]))
    else $error("step fields misrouted");
  chk_ramp_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(ramp_en) |-> ramp_dec_step == 32'h0 && ramp_pos_rate == 16'h0)
    else $error("ramp step or positive rate leaked while generator off");
  chk_pos_rate: assert property (@(posedge clk) disable iff (!rst_n)
    $past(ramp_en) |-> ramp_pos_rate == $past(rate_q[15:0]))
    else $error("positive rate misrouted");
  chk_step_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_en && wr_addr == DDSPR_ADDR_STEP) |=> $stable(step_q))
    else $error("step register changed without a write");
  chk_rate_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_en && wr_addr == DDSPR_ADDR_RATE) |=> $stable(rate_q))
    else $error("rate register changed without a write");

  // A profile keeps only the fields of the mode in force when it was written,
  // so a host that changes mode must rewrite its profiles afterwards.
  chk_prof_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && is_prof(wr_addr) |=>
      prof_q[$past(wr_addr[2:0]) - 3'h6] == ($past(wr_data) & prof_mask($past(mem_mode))))
    else $error("profile word not stored");
  chk_prof_read: assert property (@(posedge clk) disable iff (!rst_n)
    is_prof(rd_addr) |=> rd_data == $past(prof_q[rd_addr[2:0] - 3'h6]))
    else $error("profile read returned wrong word");
  chk_step_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == DDSPR_ADDR_STEP |=> rd_data == $past(step_q))
    else $error("step read returned wrong word");
  chk_rate_upper: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == DDSPR_ADDR_RATE |=> rd_data == {32'h0, $past(rate_q)})
    else $error("rate read not zero above bit 31");
  chk_tone_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_mode && wr_en && is_prof(wr_addr) |=>
      (prof_q[$past(wr_addr[2:0]) - 3'h6] & ~DDSPR_TONE_MASK) == 64'h0)
    else $error("unused tone bits stored");
  chk_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr != DDSPR_ADDR_STEP && rd_addr != DDSPR_ADDR_RATE && !is_prof(rd_addr)
      |=> rd_data == 64'h0)
    else $error("unmapped read not zero");

  // Outputs of the unused interpretation must freeze, not follow the slot.
  chk_mem_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_mode |=> $stable(mem_step_rate) && $stable(mem_play_mode))
    else $error("memory fields moved outside memory mode");
  chk_tone_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tone_mode |=> $stable(tuning_value) && $stable(amplitude_scale))
    else $error("tone fields moved outside tone mode");
  chk_seq_idle: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode && first_control_word[DDSPR_CW1_SEQ_LO +: 4] == 4'h0
      |-> active_profile == pin_q)
    else $error("sequencer took over with its field clear");

  chk_tone_amp: assert property (@(posedge clk) disable iff (!rst_n)
    tone_mode |=> amplitude_scale == $past(cur[61:48])
      && phase_offset_value == $past(cur[47:32]))
    else $error("amplitude or phase misrouted");
  chk_mem_rate: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode |=> mem_step_rate == $past(cur[55:40]))
    else $error("address step rate misrouted");
  chk_mem_addrs: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode |=> mem_end_addr == $past(cur[39:30])
      && mem_start_addr == $past(cur[23:14]))
    else $error("playback addresses misrouted");
  chk_no_dwell: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode |=> mem_no_dwell == $past(cur[5]))
    else $error("no-dwell flag misrouted");
  chk_zero_cross: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode |=> mem_zero_cross == $past(cur[3]))
    else $error("zero-crossing flag misrouted");
  chk_play_mode: assert property (@(posedge clk) disable iff (!rst_n)
    mem_mode |=> mem_play_mode == $past(cur[2:0]))
    else $error("playback mode misrouted");

endmodule // ddspr_regs
`default_nettype wire

// *** testbench/ddspr_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host side of the register port. Requests change 1 ns after a rising edge.
module ddspr_host_model (
  // Clock and read return.
  input wire logic clk,
  input wire logic [63:0] rd_data,
  // Write, read and select lines.
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [63:0] wr_data,
  output logic [7:0] rd_addr,
  output logic [2:0] profile_pins
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 64'h0;
    rd_addr = 8'h00;
    profile_pins = 3'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk) #1 wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clk) #1 wr_en = 1'b0;
    // A released data bus must not keep showing the last word.
    wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [63:0] d);
    @(posedge clk) #1 rd_addr = a;
    repeat (2) @(posedge clk);
    #1 d = rd_data;
  endtask
  task automatic sel(input logic [2:0] p);
    @(posedge clk) #1 profile_pins = p;
  endtask
endmodule // ddspr_host_model
`default_nettype wire

// *** testbench/dds_profile_ramp_registers_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module dds_profile_ramp_registers_tb;
  import ddspr_pkg::*;
  logic clk, rst_n, wr_en, mem_mode, tone_mode, mem_no_dwell, mem_zero_cross;
  logic [7:0] wr_addr, rd_addr;
  logic [63:0] wr_data, rd_data, d;
  logic [31:0] first_control_word, second_control_word, ramp_dec_step, ramp_inc_step;
  logic [2:0] profile_pins, seq_profile, active_profile, mem_play_mode;
  logic [15:0] ramp_neg_rate, ramp_pos_rate, phase_offset_value, mem_step_rate;
  logic [13:0] amplitude_scale;
  logic [31:0] tuning_value;
  logic [9:0] mem_end_addr, mem_start_addr;
  int n_errors = 0;
  int tests_run = 0;
  ddspr_regs uut (.clk, .rst_n, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data,
    .first_control_word, .second_control_word, .profile_pins, .seq_profile,
    .ramp_dec_step, .ramp_inc_step, .ramp_neg_rate, .ramp_pos_rate, .active_profile,
    .mem_mode, .tone_mode, .amplitude_scale, .phase_offset_value, .tuning_value,
    .mem_step_rate, .mem_end_addr, .mem_start_addr, .mem_no_dwell, .mem_zero_cross,
    .mem_play_mode);
  ddspr_host_model h (.clk, .rd_data, .wr_en, .wr_addr, .wr_data, .rd_addr, .profile_pins);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #40000 n_errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    first_control_word = 32'h0;
    second_control_word = 32'h0;
    seq_profile = 3'h0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int a = 12; a <= 22; a++) begin
      h.rd(8'(a), d);
      chk(d, 64'h0);
    end
    h.wr(DDSPR_ADDR_STEP, 64'hfedc_ba98_7654_3210);
    h.wr(DDSPR_ADDR_RATE, 64'hffff_ffff_1357_2468);
    h.wr(8'h16, 64'hffff_ffff_ffff_ffff);
    h.wr(8'h11, 64'hffff_5555_aaaa_0001);
    h.rd(DDSPR_ADDR_STEP, d);
    chk(d, 64'hfedc_ba98_7654_3210);
    h.rd(DDSPR_ADDR_RATE, d);
    chk(d, 64'h1357_2468);
    h.rd(8'h16, d);
    chk(d, 64'h0);
    h.rd(8'h11, d);
    chk(d, 64'h3fff_5555_aaaa_0001);
    chk({ramp_dec_step, ramp_inc_step, ramp_neg_rate, ramp_pos_rate}, 64'h0);
    h.sel(3'h3);
    repeat (8) @(posedge clk);
    #1 chk({tone_mode, mem_mode, active_profile}, 64'h13);
    chk({amplitude_scale, phase_offset_value, tuning_value}, 64'h3fff_5555_aaaa_0001);
    second_control_word = 32'h0008_0000;
    repeat (4) @(posedge clk);
    #1 chk({ramp_dec_step, ramp_inc_step}, 64'hfedc_ba98_7654_3210);
    chk({ramp_neg_rate, ramp_pos_rate}, 64'h1357_2468);
    chk(tone_mode, 64'h0);
    @(posedge clk) #1 second_control_word = 32'h0000_0010;
    @(posedge clk) #1 chk(tone_mode, 64'h0);
    second_control_word = 32'h0;
    first_control_word = 32'h8000_0000;
    h.wr(8'h13, 64'h1234_5678_9abc_def5);
    h.sel(3'h5);
    repeat (8) @(posedge clk);
    #1 chk({tone_mode, mem_mode, active_profile}, 64'hd);
    chk({mem_step_rate, mem_end_addr, mem_start_addr, mem_no_dwell, mem_zero_cross,
      mem_play_mode}, {16'h3456, 10'h1e2, 10'h2f3, 1'b1, 1'b0, 3'h5});
    h.rd(8'h13, d);
    chk(d, 64'h0034_5678_80bc_c025);
    first_control_word = 32'h8002_0000;
    seq_profile = 3'h2;
    repeat (3) @(posedge clk);
    #1 chk(active_profile, 64'h2);
    first_control_word = 32'h8000_0000;
    h.wr(8'h13, 64'h0000_0000_0000_000a);
    repeat (3) @(posedge clk);
    #1 chk({mem_no_dwell, mem_zero_cross, mem_play_mode}, 64'ha);
    chk({amplitude_scale, phase_offset_value, tuning_value}, 64'h3fff_5555_aaaa_0001);
    rst_n = 1'b0;
    @(posedge clk) #1 rst_n = 1'b1;
    h.rd(8'h13, d);
    chk(d, 64'h0);
    chk({amplitude_scale, phase_offset_value, tuning_value}, 64'h0);
    conclude();
  end
endmodule // dds_profile_ramp_registers_tb
`default_nettype wire
